// *** lad_pkg.sv ***
// Constants and types for the legacy address decoder
package lad_pkg;
	localparam int LAD_NPORT = 6;
	localparam int LAD_NSEG = 13;
	// Register byte offsets
	localparam logic [7:0] LAD_OFF_SEGATTR = 8'h00;
	localparam logic [7:0] LAD_OFF_VGA_ROUTE_ENABLE = 8'h04;
	localparam logic [7:0] LAD_OFF_SMMCTL = 8'h08;
	localparam logic [7:0] LAD_OFF_TOP_OF_LOW_MEMORY = 8'h0c;
	localparam logic [7:0] LAD_OFF_STATUS = 8'h10;
	// Reset values
	localparam logic [25:0] LAD_RST_SEGATTR = 26'h0000000;
	localparam logic [5:0] LAD_RST_VGA_ROUTE_ENABLE = 6'h00;
	localparam logic LAD_RST_SMMEN = 1'b0;
	localparam logic [3:0] LAD_RST_TOP_OF_LOW_MEMORY = 4'h1;
	// Address map
	localparam logic [31:0] LAD_DOS_TOP = 32'h0009ffff;
	localparam logic [31:0] LAD_VGA_TOP = 32'h000bffff;
	localparam logic [31:0] LAD_EXP_BASE = 32'h000c0000;
	localparam logic [31:0] LAD_EXP_TOP = 32'h000effff;
	localparam logic [31:0] LAD_BIOS_TOP = 32'h000fffff;
	localparam logic [31:0] LAD_APIC0_BASE = 32'hfec00000;
	localparam logic [31:0] LAD_APIC0_TOP = 32'hfecfffff;
	localparam logic [31:0] LAD_APIC1_BASE = 32'hfee00000;
	localparam logic [31:0] LAD_APIC1_TOP = 32'hfeefffff;
	localparam int LAD_SEG_SHIFT = 14;
	localparam int LAD_SMM_BIT = 7;
	// Attribute field bits
	localparam int LAD_ATTR_READ_MEM = 0;
	localparam int LAD_ATTR_WRITE_MEM = 1;
	typedef enum logic [2:0] {
		LAD_DST_DRAM = 3'h1,
		LAD_DST_HUB = 3'h2,
		LAD_DST_PEX = 3'h4
	} lad_dst_t;
	typedef enum logic [2:0] {
		LAD_RD_IDLE = 3'h1,
		LAD_RD_ADDR = 3'h2,
		LAD_RD_DATA = 3'h4
	} lad_rd_state_t;
endpackage

// *** lad_smm_sample.sv ***
// Captures the SMM memory indicator on the request strobe
`timescale 1ns/1ps
module lad_smm_sample
	import lad_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Processor bus pins
	input wire logic request_address_strobe_n,
	input wire logic [31:0] multiplexed_address_n,
	// Sampled request
	output logic req_valid,
	output logic [31:0] req_addr,
	output logic req_smm
);
	typedef struct packed {
		logic [1:0] ads_sync;
		logic [31:0] a_s1;
		logic [31:0] a_s2;
		logic valid;
		logic [31:0] addr;
		logic smm;
	} lad_smp_t;
	lad_smp_t st;
	lad_smp_t next_st;

	always_comb begin
		next_st = st;
		next_st.ads_sync = {st.ads_sync[0], ~request_address_strobe_n};
		next_st.a_s1 = ~multiplexed_address_n;
		next_st.a_s2 = st.a_s1;
		next_st.valid = st.ads_sync[1];
		if (st.ads_sync[1]) begin
			// Bit 7 carries the SMM indicator in the strobe clock's second half
			next_st.addr = {st.a_s2[31:8], 1'b0, st.a_s2[6:0]};
			next_st.smm = st.a_s2[LAD_SMM_BIT];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign req_valid = st.valid;
	assign req_addr = st.addr;
	assign req_smm = st.smm;

	chk_smm_capture: assert property (@(posedge aclk) disable iff (!aresetn)
		st.ads_sync[1] |=> req_valid && req_smm == $past(st.a_s2[LAD_SMM_BIT]))
		else $error("smm indicator not captured with strobe");
endmodule

// *** lad_seg_steer.sv ***
// Steers one access through a segment attribute field
`timescale 1ns/1ps
module lad_seg_steer
	import lad_pkg::*;
(
	// Attribute and access
	input wire logic [1:0] attr,
	input wire logic is_write,
	// Result
	output logic to_dram
);
	// 00 hub, 01 write hub read mem, 10 write mem read hub, 11 mem
	assign to_dram = is_write ? attr[LAD_ATTR_WRITE_MEM] : attr[LAD_ATTR_READ_MEM];
endmodule

// *** lad_decoder.sv ***
// Legacy address decoder top with AXI4-Lite registers
//
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
// How it works
// - Addresses 0 to 9FFFFh always go to main memory.
// - Video window goes to the port whose vga_route_enable is set.
// - With no port enabled the video window goes to the legacy hub.
// - Internal devices decode first in the video window, before external steering.
// - SMM overlay on video: indicator high goes to memory, else video port.
// - SMM indicator is sampled on address bit 7 with the request strobe.
// - Enabled SMM space: SMM processor accesses hit DRAM, others video.
// - Inbound accesses never reach SMM DRAM; treated as video accesses.
// - Monochrome range B0000h-B7FFFh gets no special decoding.
// - C0000h-DFFFFh is eight 16 KB segments with own attributes.
// - Attribute 00 hub, 01 read mem, 10 write mem, 11 both mem.
// - Expansion segments reset to hub for reads and writes.
// - Locked accesses to split segments complete, atomicity not guaranteed.
// - E0000h-EFFFFh is four 16 KB segments, reset to hub.
// - F0000h-FFFFFh is one 64 KB segment, reset to hub.
// - 1 MB up to top of low memory goes to DRAM, max 3.75 GB.
// - Interrupt-controller windows are never remapped onto memory.
module lad_decoder
	import lad_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Processor bus pins
	input wire logic request_address_strobe_n,
	input wire logic [31:0] multiplexed_address_n,
	input wire logic proc_is_write,
	// Inbound request from the I/O ports
	input wire logic in_valid,
	input wire logic [31:0] in_addr,
	input wire logic in_is_write,
	input wire logic in_lock,
	// Internal device hit in the video window
	input wire logic internal_hit,
	// Decode result
	output logic route_valid,
	output lad_pkg::lad_dst_t route_dst,
	output logic [2:0] route_port,
	output logic route_lock_split,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import lad_pkg::*;

	typedef struct packed {
		logic [25:0] seg_attr;
		logic [5:0] vga_en;
		logic smm_en;
		logic [3:0] top_of_low_memory;
		logic aw_held;
		logic [7:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rt_valid;
		lad_dst_t rt_dst;
		logic [2:0] rt_port;
		logic rt_split;
		logic [15:0] proc_cnt;
		logic [15:0] in_cnt;
	} lad_top_t;
	lad_top_t st;
	lad_top_t next_st;

	logic p_valid;
	logic [31:0] p_addr;
	logic p_smm;

	lad_smm_sample u_smm (
		.aclk(aclk),
		.aresetn(aresetn),
		.request_address_strobe_n(request_address_strobe_n),
		.multiplexed_address_n(multiplexed_address_n),
		.req_valid(p_valid),
		.req_addr(p_addr),
		.req_smm(p_smm)
	);

	// Processor requests win; an inbound request in the same cycle is not decoded
	logic use_proc;
	logic [31:0] a;
	logic wr;
	logic inbound;
	logic [3:0] seg_idx;
	logic [1:0] cur_attr;
	logic seg_dram;
	assign use_proc = p_valid;
	assign a = use_proc ? p_addr : in_addr;
	assign wr = use_proc ? proc_is_write : in_is_write;
	assign inbound = !use_proc;

	always_comb begin
		seg_idx = 4'h0;
		if (a[19:16] == 4'hf) begin
			seg_idx = 4'hc;
		end else begin
			seg_idx = 4'(a[19:LAD_SEG_SHIFT] - 6'h30);
		end
	end
	assign cur_attr = st.seg_attr[2*seg_idx +: 2];

	lad_seg_steer u_steer (
		.attr(cur_attr),
		.is_write(wr),
		.to_dram(seg_dram)
	);

	// Lowest set enable wins should software break the one-port rule
	logic vga_any;
	logic [2:0] vga_port;
	always_comb begin
		vga_port = 3'h0;
		for (int i = LAD_NPORT - 1; i >= 0; i--) begin
			if (st.vga_en[i]) begin
				vga_port = 3'(i);
			end
		end
	end
	assign vga_any = |st.vga_en;

	logic [31:0] rd_mux;
	always_comb begin
		case (s_axi_araddr)
			LAD_OFF_SEGATTR: rd_mux = {6'h00, st.seg_attr};
			LAD_OFF_VGA_ROUTE_ENABLE: rd_mux = {26'h0, st.vga_en};
			LAD_OFF_SMMCTL: rd_mux = {31'h0, st.smm_en};
			LAD_OFF_TOP_OF_LOW_MEMORY: rd_mux = {28'h0, st.top_of_low_memory};
			LAD_OFF_STATUS: rd_mux = {st.in_cnt, st.proc_cnt};
			default: rd_mux = 32'h0;
		endcase
	end

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction

	logic [31:0] wm;
	always_comb begin
		next_st = st;
		wm = 32'h0;
		// Write channel: take address and data in either order
		next_st.awready = !st.aw_held && !st.bvalid;
		next_st.wready = !st.w_held && !st.bvalid;
		if (s_axi_awvalid && st.awready) begin
			next_st.aw_held = 1'b1;
			next_st.aw_addr = s_axi_awaddr;
			next_st.awready = 1'b0;
		end
		if (s_axi_wvalid && st.wready) begin
			next_st.w_held = 1'b1;
			next_st.w_data = s_axi_wdata;
			next_st.w_strb = s_axi_wstrb;
			next_st.wready = 1'b0;
		end
		if (st.aw_held && st.w_held && !st.bvalid) begin
			next_st.aw_held = 1'b0;
			next_st.w_held = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = 2'b00;
			case (st.aw_addr)
				LAD_OFF_SEGATTR: begin
					wm = merge({6'h00, st.seg_attr}, st.w_data, st.w_strb);
					next_st.seg_attr = wm[25:0];
				end
				LAD_OFF_VGA_ROUTE_ENABLE: begin
					wm = merge({26'h0, st.vga_en}, st.w_data, st.w_strb);
					next_st.vga_en = wm[5:0];
				end
				LAD_OFF_SMMCTL: begin
					wm = merge({31'h0, st.smm_en}, st.w_data, st.w_strb);
					next_st.smm_en = wm[0];
				end
				LAD_OFF_TOP_OF_LOW_MEMORY: begin
					wm = merge({28'h0, st.top_of_low_memory}, st.w_data, st.w_strb);
					next_st.top_of_low_memory = wm[3:0];
				end
				LAD_OFF_STATUS: begin
				end
				default: next_st.bresp = 2'b10;
			endcase
		end
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		// Read channel answers one cycle after the address is taken
		next_st.arready = !st.rvalid && !(s_axi_arvalid && st.arready);
		if (s_axi_arvalid && st.arready) begin
			next_st.rvalid = 1'b1;
			next_st.rdata = rd_mux;
			next_st.rresp = (s_axi_araddr inside {LAD_OFF_SEGATTR, LAD_OFF_VGA_ROUTE_ENABLE, LAD_OFF_SMMCTL,
				LAD_OFF_TOP_OF_LOW_MEMORY, LAD_OFF_STATUS}) ? 2'b00 : 2'b10;
		end
		if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		// Address decode, one cycle after the request
		next_st.rt_valid = p_valid || in_valid;
		next_st.rt_port = 3'h0;
		next_st.rt_split = 1'b0;
		next_st.rt_dst = LAD_DST_HUB;
		if (p_valid || in_valid) begin
			if (a <= LAD_DOS_TOP) begin
				next_st.rt_dst = LAD_DST_DRAM;
			end else if (a <= LAD_VGA_TOP) begin
				// Monochrome range shares the video decode with no carve-out
				if (internal_hit) begin
					next_st.rt_dst = LAD_DST_HUB;
				end else if (st.smm_en && !inbound && p_smm) begin
					next_st.rt_dst = LAD_DST_DRAM;
				end else if (vga_any) begin
					next_st.rt_dst = LAD_DST_PEX;
					next_st.rt_port = vga_port;
				end else begin
					next_st.rt_dst = LAD_DST_HUB;
				end
			end else if (a <= LAD_BIOS_TOP) begin
				next_st.rt_dst = seg_dram ? LAD_DST_DRAM : LAD_DST_HUB;
				// Split destinations break locked atomicity; flag it and complete anyway
				next_st.rt_split = inbound && in_lock && (cur_attr[0] != cur_attr[1]);
			end else if ((a >= LAD_APIC0_BASE && a <= LAD_APIC0_TOP) ||
				(a >= LAD_APIC1_BASE && a <= LAD_APIC1_TOP)) begin
				next_st.rt_dst = LAD_DST_HUB;
			end else if (a[31:28] < st.top_of_low_memory) begin
				next_st.rt_dst = LAD_DST_DRAM;
			end else begin
				next_st.rt_dst = LAD_DST_HUB;
			end
			if (use_proc) begin
				next_st.proc_cnt = st.proc_cnt + 16'h1;
			end else begin
				next_st.in_cnt = st.in_cnt + 16'h1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
			st.seg_attr <= LAD_RST_SEGATTR;
			st.vga_en <= LAD_RST_VGA_ROUTE_ENABLE;
			st.smm_en <= LAD_RST_SMMEN;
			st.top_of_low_memory <= LAD_RST_TOP_OF_LOW_MEMORY;
			st.rt_dst <= LAD_DST_HUB;
		end else begin
			st <= next_st;
		end
	end

	assign s_axi_awready = st.awready;
	assign s_axi_wready = st.wready;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_arready = st.arready;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.rresp;
	assign route_valid = st.rt_valid;
	assign route_dst = st.rt_dst;
	assign route_port = st.rt_port;
	assign route_lock_split = st.rt_split;

	chk_dos_dram: assert property (@(posedge aclk) disable iff (!aresetn)
		(p_valid || in_valid) && a <= LAD_DOS_TOP |=> route_dst == LAD_DST_DRAM)
		else $error("low 640 KB not sent to memory");
	chk_vga_port: assert property (@(posedge aclk) disable iff (!aresetn)
		(p_valid || in_valid) && a > LAD_DOS_TOP && a <= LAD_VGA_TOP && !internal_hit && vga_any
		&& !(st.smm_en && use_proc && p_smm) |=> route_dst == LAD_DST_PEX && route_port == $past(vga_port))
		else $error("video window not steered to enabled port");
	chk_vga_default: assert property (@(posedge aclk) disable iff (!aresetn)
		(p_valid || in_valid) && a > LAD_DOS_TOP && a <= LAD_VGA_TOP && !vga_any
		&& !(st.smm_en && use_proc && p_smm) |=> route_dst == LAD_DST_HUB)
		else $error("video window default not hub");
	chk_smm_mem: assert property (@(posedge aclk) disable iff (!aresetn)
		p_valid && p_smm && st.smm_en && !internal_hit && p_addr > LAD_DOS_TOP && p_addr <= LAD_VGA_TOP
		|=> route_dst == LAD_DST_DRAM)
		else $error("smm access not sent to memory");
	chk_inbound_smm: assert property (@(posedge aclk) disable iff (!aresetn)
		!p_valid && in_valid && in_addr > LAD_DOS_TOP && in_addr <= LAD_VGA_TOP
		|=> route_dst != LAD_DST_DRAM)
		else $error("inbound reached smm memory");
	chk_seg_steer: assert property (@(posedge aclk) disable iff (!aresetn)
		(p_valid || in_valid) && a > LAD_VGA_TOP && a <= LAD_BIOS_TOP
		|=> (route_dst == LAD_DST_DRAM) == $past(wr ? cur_attr[1] : cur_attr[0]))
		else $error("segment attribute steering wrong");
	chk_apic_hole: assert property (@(posedge aclk) disable iff (!aresetn)
		(p_valid || in_valid) && a >= LAD_APIC0_BASE && a <= LAD_APIC0_TOP |=> route_dst != LAD_DST_DRAM)
		else $error("interrupt window mapped to memory");
	chk_reset_attr: assert property (@(posedge aclk)
		$rose(aresetn) |-> st.seg_attr == LAD_RST_SEGATTR && st.vga_en == LAD_RST_VGA_ROUTE_ENABLE)
		else $error("attribute reset value wrong");
	chk_rd_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	cov_smm: cover property (@(posedge aclk) disable iff (!aresetn) route_valid && route_dst == LAD_DST_DRAM && $past(p_smm));
	cov_pex: cover property (@(posedge aclk) disable iff (!aresetn) route_valid && route_dst == LAD_DST_PEX);
	cov_split: cover property (@(posedge aclk) disable iff (!aresetn) route_lock_split);
	cov_write: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid && s_axi_bready);
endmodule

// *** lad_fsb_model.sv ***
// Processor bus model that issues requests carrying the SMM indicator
`timescale 1ns/1ps
module lad_fsb_model (
	// Clock
	input wire logic aclk,
	// Processor bus pins
	output logic request_address_strobe_n,
	output logic [31:0] multiplexed_address_n,
	output logic proc_is_write
);
	initial begin
		request_address_strobe_n = 1'b1;
		multiplexed_address_n = 32'hffffffff;
		proc_is_write = 1'b0;
	end
	// Write flag stays until the next request because decode looks at it late
	task automatic req(input logic [31:0] a, input logic smm, input logic wr);
		@(posedge aclk);
		request_address_strobe_n <= 1'b0;
		multiplexed_address_n <= ~{a[31:8], smm, a[6:0]};
		proc_is_write <= wr;
		@(posedge aclk);
		request_address_strobe_n <= 1'b1;
		// Released pins flip so a stale address is never read as valid
		multiplexed_address_n <= {a[31:8], smm, a[6:0]};
	endtask
endmodule

// *** tb_top.sv ***
// Self-checking bench for the legacy address decoder
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; $display("FAIL %s exp %h got %h", nm, e, g); end end
module tb_top;
	import lad_pkg::*;
	logic aclk, aresetn, rasn, pw, in_valid, in_is_write, in_lock, internal_hit;
	logic [31:0] man, in_addr, wdata, rdata, sv, a;
	logic route_valid, route_lock_split, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [2:0] route_port;
	logic [7:0] awaddr, araddr;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	lad_dst_t route_dst;
	int num_errors = 0;
	int n_checks = 0;
	int cyc = 0;
	int k;
	lad_fsb_model fsb (.aclk(aclk), .request_address_strobe_n(rasn), .multiplexed_address_n(man), .proc_is_write(pw));
	lad_decoder uut (.aclk(aclk), .aresetn(aresetn), .request_address_strobe_n(rasn),
		.multiplexed_address_n(man), .proc_is_write(pw), .in_valid(in_valid), .in_addr(in_addr),
		.in_is_write(in_is_write), .in_lock(in_lock), .internal_hit(internal_hit),
		.route_valid(route_valid), .route_dst(route_dst), .route_port(route_port),
		.route_lock_split(route_lock_split), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	task automatic finish_test;
		if (num_errors == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Whole run needs well under this many cycles
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			num_errors++;
			finish_test;
		end
	end
	task automatic axw(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		logic ga, gw;
		ga = 1'b1;
		gw = 1'b1;
		@(posedge aclk);
		awaddr <= ad;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (ga && awready === 1'b1) begin
				awvalid <= 1'b0;
				ga = 1'b0;
			end
			if (gw && wready === 1'b1) begin
				wvalid <= 1'b0;
				gw = 1'b0;
			end
		end while (ga || gw);
		while (bvalid !== 1'b1) @(posedge aclk);
		bready <= 1'b0;
		`CHK("bresp", er, bresp)
	endtask
	task automatic axr(input logic [7:0] ad, input logic [31:0] ed, input logic [1:0] er);
		@(posedge aclk);
		araddr <= ad;
		arvalid <= 1'b1;
		rready <= 1'b1;
		@(posedge aclk);
		while (arready !== 1'b1) @(posedge aclk);
		arvalid <= 1'b0;
		@(posedge aclk);
		while (rvalid !== 1'b1) @(posedge aclk);
		rready <= 1'b0;
		`CHK("rdata", ed, rdata)
		`CHK("rresp", er, rresp)
	endtask
	// Result pulse lasts one cycle, so it is looked at after every edge
	task automatic wt(input lad_dst_t ed, input logic [2:0] ep, input logic es);
		int t;
		t = 0;
		do begin
			@(posedge aclk);
			in_valid <= 1'b0;
			#1;
			t++;
		end while (route_valid !== 1'b1 && t < 12);
		`CHK("route_valid", 1'b1, route_valid)
		`CHK("route_dst", ed, route_dst)
		if (ed == LAD_DST_PEX) `CHK("route_port", ep, route_port)
		`CHK("route_lock_split", es, route_lock_split)
	endtask
	task automatic pr(input logic [31:0] ad, input logic smm, input logic wr, input lad_dst_t ed, input logic [2:0] ep);
		fsb.req(ad, smm, wr);
		wt(ed, ep, 1'b0);
	endtask
	task automatic ib(input logic [31:0] ad, input logic wr, input logic lk, input lad_dst_t ed,
		input logic [2:0] ep, input logic es);
		@(posedge aclk);
		in_valid <= 1'b1;
		in_addr <= ad;
		in_is_write <= wr;
		in_lock <= lk;
		wt(ed, ep, es);
	endtask
	initial begin
		{aresetn, in_valid, in_addr, in_is_write, in_lock, internal_hit} = '0;
		{awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		axr(LAD_OFF_SEGATTR, 32'h0, 2'h0);
		axr(LAD_OFF_VGA_ROUTE_ENABLE, 32'h0, 2'h0);
		axr(LAD_OFF_SMMCTL, 32'h0, 2'h0);
		axr(LAD_OFF_TOP_OF_LOW_MEMORY, 32'h1, 2'h0);
		axr(8'h20, 32'h0, 2'h2);
		axw(8'h20, 32'h5, 4'hf, 2'h2);
		pr(32'h00000000, 1'b0, 1'b0, LAD_DST_DRAM, 3'h0);
		pr(32'h0009ff40, 1'b0, 1'b1, LAD_DST_DRAM, 3'h0);
		pr(32'h000a0000, 1'b0, 1'b0, LAD_DST_HUB, 3'h0);
		pr(32'h000c0000, 1'b0, 1'b0, LAD_DST_HUB, 3'h0);
		pr(32'h000e4000, 1'b0, 1'b1, LAD_DST_HUB, 3'h0);
		pr(32'h000f0000, 1'b0, 1'b1, LAD_DST_HUB, 3'h0);
		pr(32'h00100000, 1'b0, 1'b0, LAD_DST_DRAM, 3'h0);
		pr(32'h0fffff00, 1'b0, 1'b1, LAD_DST_DRAM, 3'h0);
		pr(32'h10000000, 1'b0, 1'b0, LAD_DST_HUB, 3'h0);
		axw(LAD_OFF_VGA_ROUTE_ENABLE, 32'h8, 4'hf, 2'h0);
		pr(32'h000bff00, 1'b0, 1'b0, LAD_DST_PEX, 3'h3);
		pr(32'h000b4000, 1'b0, 1'b1, LAD_DST_PEX, 3'h3);
		@(posedge aclk);
		internal_hit <= 1'b1;
		pr(32'h000a0000, 1'b0, 1'b0, LAD_DST_HUB, 3'h0);
		@(posedge aclk);
		internal_hit <= 1'b0;
		pr(32'h000a0000, 1'b1, 1'b0, LAD_DST_PEX, 3'h3);
		axw(LAD_OFF_SMMCTL, 32'h1, 4'hf, 2'h0);
		pr(32'h000a0000, 1'b1, 1'b1, LAD_DST_DRAM, 3'h0);
		pr(32'h000bff00, 1'b0, 1'b0, LAD_DST_PEX, 3'h3);
		ib(32'h000a0000, 1'b0, 1'b0, LAD_DST_PEX, 3'h3, 1'b0);
		axw(LAD_OFF_VGA_ROUTE_ENABLE, 32'h0, 4'hf, 2'h0);
		pr(32'h000a0000, 1'b1, 1'b0, LAD_DST_DRAM, 3'h0);
		pr(32'h000a0000, 1'b0, 1'b0, LAD_DST_HUB, 3'h0);
		ib(32'h000a0000, 1'b1, 1'b0, LAD_DST_HUB, 3'h0, 1'b0);
		sv = 32'h0;
		for (k = 0; k < LAD_NSEG; k++) sv[2 * k +: 2] = k[1:0];
		axw(LAD_OFF_SEGATTR, sv, 4'hf, 2'h0);
		axw(LAD_OFF_SEGATTR, 32'h0, 4'h0, 2'h0);
		axr(LAD_OFF_SEGATTR, sv, 2'h0);
		for (k = 0; k < LAD_NSEG; k++) begin
			a = 32'h000c0000 + 32'h4000 * k;
			pr(a, 1'b0, 1'b0, k[0] ? LAD_DST_DRAM : LAD_DST_HUB, 3'h0);
			pr(a + 32'h3f00, 1'b0, 1'b1, k[1] ? LAD_DST_DRAM : LAD_DST_HUB, 3'h0);
		end
		ib(32'h000c4000, 1'b0, 1'b1, LAD_DST_DRAM, 3'h0, 1'b1);
		ib(32'h000c4000, 1'b1, 1'b1, LAD_DST_HUB, 3'h0, 1'b1);
		ib(32'h000cc000, 1'b1, 1'b1, LAD_DST_DRAM, 3'h0, 1'b0);
		ib(32'h000c0000, 1'b0, 1'b1, LAD_DST_HUB, 3'h0, 1'b0);
		axw(LAD_OFF_TOP_OF_LOW_MEMORY, 32'hf, 4'hf, 2'h0);
		pr(32'hefffff00, 1'b0, 1'b0, LAD_DST_DRAM, 3'h0);
		pr(32'hfec00000, 1'b0, 1'b0, LAD_DST_HUB, 3'h0);
		pr(32'hfee00000, 1'b0, 1'b1, LAD_DST_HUB, 3'h0);
		// Status is read-only: the write is accepted and leaves both counters alone
		axw(LAD_OFF_STATUS, 32'hffffffff, 4'hf, 2'h0);
		// 46 processor and 6 inbound decodes were issued above
		axr(LAD_OFF_STATUS, 32'h0006002e, 2'h0);
		finish_test;
	end
endmodule
